// ==== inc/coc_pkg.sv ====
// Behaviour
// [R1] Depletion code picks falling threshold, reset 11
// [R2] Depleted during discharge: battery off, adapter on
// [R3] Depletion clears only after 340mV rising hysteresis
// [R4] Zero charge voltage disables depletion protection
// [R5] Frequency direction: 0 lowers, 1 raises 18%
// [R6] Frequency enable gates shift, reset off
// [R7] High-side short: 0 off, 1 750mV default
// [R8] Low-side short: 0 135mV default, 1 230mV
// [R9] Writing discharge bit 1 starts battery discharge
// [R10] Threshold reached ends discharge, adapter takes over
// [R11] Completed discharge clears its bit; reset 0
// [R12] Writing 0 aborts discharge, adapter path on
// [R13] Monitor select: 0 adapter, 1 charge amplifier
// [R14] Adapter present is read-only, reset 0
// [R15] Adapter overcurrent: 0 off, 1 3.33x default
// [R16] Inhibit bit stops charging; bits 3,2 inert
// [R17] Word read/write over SMBus, command 0x12
package coc_pkg;

	// Option register command and contents
	localparam logic [7:0] CMD_OPTION = 8'h12;
	localparam logic [15:0] OPT_RESET = 16'h1902;
	localparam logic [15:0] OPT_WMASK = 16'h1FEF;
	localparam logic [2:0] OPT_UPPER_READ = 3'h0;

	// Field positions
	localparam int POS_INHIBIT = 0;
	localparam int POS_ADP_OVC = 1;
	localparam int POS_ADP = 4;
	localparam int POS_MON = 5;
	localparam int POS_LEARN = 6;
	localparam int POS_LSHORT = 7;
	localparam int POS_HSHORT = 8;
	localparam int POS_FEN = 9;
	localparam int POS_FDIR = 10;
	localparam int POS_DEPL_LO = 11;
	localparam int POS_DEPL_HI = 12;

	// Depletion threshold codes, percent of regulation limit
	localparam logic [1:0] DEPL_5919 = 2'h0;
	localparam logic [1:0] DEPL_6265 = 2'h1;
	localparam logic [1:0] DEPL_6655 = 2'h2;
	localparam logic [1:0] DEPL_7097 = 2'h3;

	// Byte positions within a transaction
	localparam logic [1:0] IDX_ADDR = 2'h0;
	localparam logic [1:0] IDX_CMD = 2'h1;
	localparam logic [1:0] IDX_LO = 2'h2;
	localparam logic [1:0] IDX_HI = 2'h3;
	localparam logic [2:0] BIT_LAST = 3'h7;

	// Synchroniser lanes
	localparam int SYN_SCL = 0;
	localparam int SYN_SDA = 1;
	localparam int SYN_ADP = 2;
	localparam int SYN_BELOW = 3;
	localparam int SYN_ABOVE = 4;
	localparam int SYN_W = 5;

	typedef enum logic [2:0] {
		COC_IDLE,
		COC_RX,
		COC_ACK_SETUP,
		COC_ACK,
		COC_TX,
		COC_MACK,
		COC_NEXT,
		COC_IGNORE
	} coc_state_t;

endpackage

// ==== src/coc_option_ctrl.sv ====
`timescale 1ns/1ns
module coc_option_ctrl #(
	parameter logic [6:0] SMB_ADDR = 7'h2A
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// SMBus pins
	input wire logic smb_clk,
	input wire logic smb_data_in,
	output logic smb_data_out,
	output logic smb_data_oe,
	// Analog status
	input wire logic adapter_detect_input,
	input wire logic battery_below_falling,
	input wire logic battery_above_rising,
	input wire logic [15:0] charge_voltage_setting,
	// Option outputs
	output logic [1:0] depletion_threshold_sel,
	output logic freq_adjust_up,
	output logic freq_adjust_en,
	output logic high_side_short_threshold,
	output logic low_side_short_threshold,
	output logic current_monitor_sel,
	output logic adapter_overcurrent_threshold,
	output logic charge_inhibit,
	// Power path
	output logic battery_path_switch,
	output logic adapter_path_switch,
	output logic adapter_present,
	output logic learn_active
);
	import coc_pkg::*;

	logic [SYN_W-1:0] syn;
	logic scl_s, sda_s, adp_s, below_s, above_s;
	logic start_c, stop_c, scl_rise, scl_fall, ack, commit, rd_load, prot_en;
	logic [7:0] byte_in;
	logic [15:0] wr_word;
	coc_state_t state_reg, state_next;
	logic [2:0] bit_cnt_reg, bit_cnt_next;
	logic [1:0] idx_reg, idx_next;
	logic [7:0] shift_reg, shift_next, lo_reg, lo_next, tx_reg, tx_next;
	logic rw_reg, rw_next, cmd_ok_reg, cmd_ok_next, tx_hi_reg, tx_hi_next;
	logic [15:0] rd_word_reg, rd_word_next;
	logic oe_reg, oe_next, scl_d_reg, sda_d_reg;
	logic [15:0] opt_reg, opt_next;
	logic depleted_reg, depleted_next, bat_sw_reg, bat_sw_next;
	logic adp_sw_reg, adp_sw_next, adp_reg, adp_next, out_reg;

	generate
		if (SMB_ADDR < 7'h08 || SMB_ADDR > 7'h77) begin : g_bad_addr
			$error("SMB_ADDR lies in a reserved range");
		end
	endgenerate

	coc_sync #(.W(SYN_W)) u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.async_in({battery_above_rising, battery_below_falling, adapter_detect_input,
			smb_data_in, smb_clk}),
		.sync_out(syn)
	);

	assign scl_s = syn[SYN_SCL];
	assign sda_s = syn[SYN_SDA];
	assign adp_s = syn[SYN_ADP];
	assign below_s = syn[SYN_BELOW];
	assign above_s = syn[SYN_ABOVE];
	assign start_c = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	assign stop_c = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
	assign scl_rise = scl_s & ~scl_d_reg;
	assign scl_fall = ~scl_s & scl_d_reg;
	assign byte_in = {shift_reg[6:0], sda_s};

	// Bus protocol engine
	always_comb begin
		state_next = state_reg;
		bit_cnt_next = bit_cnt_reg;
		idx_next = idx_reg;
		shift_next = shift_reg;
		lo_next = lo_reg;
		tx_next = tx_reg;
		rw_next = rw_reg;
		cmd_ok_next = cmd_ok_reg;
		tx_hi_next = tx_hi_reg;
		rd_word_next = rd_word_reg;
		oe_next = oe_reg;
		ack = 1'b0;
		commit = 1'b0;
		rd_load = 1'b0;
		wr_word = {byte_in, lo_reg};
		if (start_c) begin
			state_next = COC_RX;
			bit_cnt_next = 3'h0;
			idx_next = IDX_ADDR;
			oe_next = 1'b0;
		end else if (stop_c) begin
			state_next = COC_IDLE;
			oe_next = 1'b0;
			cmd_ok_next = 1'b0;
		end else begin
			unique case (state_reg)
				COC_IDLE, COC_IGNORE: begin
				end
				COC_RX: if (scl_rise) begin
					shift_next = byte_in;
					bit_cnt_next = bit_cnt_reg + 3'h1;
					if (bit_cnt_reg == BIT_LAST) begin
						unique case (idx_reg)
							IDX_ADDR: begin
								ack = (byte_in[7:1] == SMB_ADDR) && (!byte_in[0] || cmd_ok_reg);
								rw_next = byte_in[0];
								rd_load = ack && byte_in[0];
							end
							IDX_CMD: begin
								ack = (byte_in == CMD_OPTION); // [R17]
								cmd_ok_next = ack;
							end
							IDX_LO: begin
								ack = 1'b1;
								lo_next = byte_in;
							end
							IDX_HI: begin
								ack = 1'b1;
								commit = 1'b1; // [R17]
							end
						endcase
						state_next = ack ? COC_ACK_SETUP : COC_IGNORE;
					end
				end
				COC_ACK_SETUP: if (scl_fall) begin
					oe_next = 1'b1;
					state_next = COC_ACK;
				end
				COC_ACK: if (scl_fall) begin
					bit_cnt_next = 3'h0;
					if (rw_reg) begin
						tx_next = rd_word_reg[7:0];
						tx_hi_next = 1'b0;
						oe_next = ~rd_word_reg[7];
						state_next = COC_TX;
					end else begin
						oe_next = 1'b0;
						idx_next = idx_reg + 2'h1;
						state_next = (idx_reg == IDX_HI) ? COC_IGNORE : COC_RX;
					end
				end
				COC_TX: if (scl_fall) begin
					bit_cnt_next = bit_cnt_reg + 3'h1;
					tx_next = {tx_reg[6:0], 1'b0};
					oe_next = (bit_cnt_reg == BIT_LAST) ? 1'b0 : ~tx_reg[6];
					if (bit_cnt_reg == BIT_LAST) begin
						state_next = COC_MACK;
					end
				end
				COC_MACK: if (scl_rise) begin
					state_next = (sda_s || tx_hi_reg) ? COC_IGNORE : COC_NEXT;
				end
				COC_NEXT: if (scl_fall) begin
					tx_next = rd_word_reg[15:8];
					tx_hi_next = 1'b1;
					bit_cnt_next = 3'h0;
					oe_next = ~rd_word_reg[15];
					state_next = COC_TX;
				end
			endcase
		end
		if (rd_load) begin
			rd_word_next = {OPT_UPPER_READ, opt_reg[POS_DEPL_HI:POS_MON], adp_reg,
				opt_reg[3:0]}; // [R14]
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_reg <= COC_IDLE;
			bit_cnt_reg <= 3'h0;
			idx_reg <= IDX_ADDR;
			shift_reg <= 8'h00;
			lo_reg <= 8'h00;
			tx_reg <= 8'h00;
			rw_reg <= 1'b0;
			cmd_ok_reg <= 1'b0;
			tx_hi_reg <= 1'b0;
			rd_word_reg <= 16'h0000;
			oe_reg <= 1'b0;
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
			out_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			bit_cnt_reg <= bit_cnt_next;
			idx_reg <= idx_next;
			shift_reg <= shift_next;
			lo_reg <= lo_next;
			tx_reg <= tx_next;
			rw_reg <= rw_next;
			cmd_ok_reg <= cmd_ok_next;
			tx_hi_reg <= tx_hi_next;
			rd_word_reg <= rd_word_next;
			oe_reg <= oe_next;
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
			out_reg <= 1'b0;
		end
	end

	// Option register, depletion and power path
	always_comb begin
		prot_en = (charge_voltage_setting != 16'h0000); // [R4]
		if (!prot_en) begin
			depleted_next = 1'b0; // [R4]
		end else if (below_s) begin
			depleted_next = 1'b1;
		end else if (above_s) begin
			depleted_next = 1'b0; // [R3]
		end else begin
			depleted_next = depleted_reg; // [R3]
		end
		opt_next = opt_reg;
		if (commit) begin
			opt_next = wr_word & OPT_WMASK; // [R9] [R12] [R16]
		end else if (opt_reg[POS_LEARN] && depleted_reg && prot_en) begin
			opt_next[POS_LEARN] = 1'b0; // [R10] [R11]
		end
		bat_sw_next = opt_next[POS_LEARN]; // [R2] [R9] [R10] [R12]
		adp_sw_next = ~opt_next[POS_LEARN]; // [R2] [R9] [R10] [R12]
		adp_next = adp_s; // [R14]
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			opt_reg <= OPT_RESET; // [R1] [R5] [R6] [R7] [R8] [R11] [R13] [R15] [R16]
			depleted_reg <= 1'b0;
			bat_sw_reg <= 1'b0;
			adp_sw_reg <= 1'b1;
			adp_reg <= 1'b0;
		end else begin
			opt_reg <= opt_next;
			depleted_reg <= depleted_next;
			bat_sw_reg <= bat_sw_next;
			adp_sw_reg <= adp_sw_next;
			adp_reg <= adp_next;
		end
	end

	assign smb_data_out = out_reg;
	assign smb_data_oe = oe_reg;
	assign depletion_threshold_sel = opt_reg[POS_DEPL_HI:POS_DEPL_LO]; // [R1]
	assign freq_adjust_up = opt_reg[POS_FDIR]; // [R5]
	assign freq_adjust_en = opt_reg[POS_FEN]; // [R6]
	assign high_side_short_threshold = opt_reg[POS_HSHORT]; // [R7]
	assign low_side_short_threshold = opt_reg[POS_LSHORT]; // [R8]
	assign current_monitor_sel = opt_reg[POS_MON]; // [R13]
	assign adapter_overcurrent_threshold = opt_reg[POS_ADP_OVC]; // [R15]
	assign charge_inhibit = opt_reg[POS_INHIBIT]; // [R16]
	assign battery_path_switch = bat_sw_reg;
	assign adapter_path_switch = adp_sw_reg;
	assign adapter_present = adp_reg;
	assign learn_active = opt_reg[POS_LEARN];

	// Checks
	AST_DEPL_END: assert property (@(posedge clk) disable iff (sys_rst) // [R10]
		learn_active && depleted_reg && prot_en && !commit |=> !learn_active ##0 adapter_path_switch)
		else $error("discharge did not end at depletion");
	AST_PROT_OFF: assert property (@(posedge clk) disable iff (sys_rst) // [R4]
		charge_voltage_setting == 16'h0000 |=> !depleted_reg)
		else $error("depletion active with zero charge voltage");
	AST_HYST: assert property (@(posedge clk) disable iff (sys_rst) // [R3]
		depleted_reg && prot_en && !above_s |=> depleted_reg)
		else $error("depletion cleared without hysteresis");
	AST_SWITCH_EXCL: assert property (@(posedge clk) disable iff (sys_rst) // [R2]
		battery_path_switch != adapter_path_switch)
		else $error("path switches not complementary");
	AST_ABORT: assert property (@(posedge clk) disable iff (sys_rst) // [R12]
		commit && !wr_word[POS_LEARN] |=> !learn_active && adapter_path_switch
		&& !battery_path_switch)
		else $error("abort did not restore adapter path");
	AST_START: assert property (@(posedge clk) disable iff (sys_rst) // [R9]
		commit && wr_word[POS_LEARN] |=> learn_active && battery_path_switch
		&& !adapter_path_switch)
		else $error("discharge did not start");
	AST_RO_BIT: assert property (@(posedge clk) disable iff (sys_rst) // [R14]
		rd_load |=> rd_word_reg[POS_ADP] == $past(adp_reg) && !opt_reg[POS_ADP])
		else $error("adapter present bit not read-only status");
	AST_FIELD_OUT: assert property (@(posedge clk) disable iff (sys_rst) // [R1]
		commit |=> depletion_threshold_sel == $past(wr_word[POS_DEPL_HI:POS_DEPL_LO])
		&& freq_adjust_up == $past(wr_word[POS_FDIR]))
		else $error("written fields not applied");
	AST_ACK_DRIVE: assert property (@(posedge clk) disable iff (sys_rst) // [R17]
		state_reg == COC_ACK_SETUP && scl_fall && !start_c && !stop_c |=> smb_data_oe)
		else $error("acknowledge not driven");
endmodule

// ==== src/coc_sync.sv ====
`timescale 1ns/1ns
module coc_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Lanes
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] meta_next;
	logic [W-1:0] sync_reg;
	logic [W-1:0] sync_next;

	generate
		if (W < 1) begin : g_bad
			$error("coc_sync width must be at least 1");
		end
	endgenerate

	always_comb begin
		meta_next = async_in;
		sync_next = meta_reg;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
		end
	end

	assign sync_out = sync_reg;
endmodule

// ==== verification/coc_smb_host.sv ====
`timescale 1ns/1ns
module coc_smb_host (
	// Clock
	input wire logic clk,
	// Bus pins
	output logic scl,
	output logic sda_drv,
	input wire logic sda
);
	import coc_pkg::*;
	logic [7:0] rx;
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Data moves only well inside the low phase
	task automatic bit_io(input logic b, output logic r);
		sda_drv = b;
		tick(10);
		scl = 1'b1;
		tick(5);
		r = sda;
		tick(5);
		scl = 1'b0;
		tick(5);
	endtask
	task automatic byte_io(input logic [7:0] d, input logic ack_in, output logic ack);
		for (int i = 7; i >= 0; i--) bit_io(d[i], rx[i]);
		bit_io(ack_in, ack);
	endtask
	task automatic start;
		sda_drv = 1'b1;
		tick(5);
		scl = 1'b1;
		tick(10);
		sda_drv = 1'b0;
		tick(10);
		scl = 1'b0;
		tick(5);
	endtask
	task automatic stop;
		sda_drv = 1'b0;
		tick(5);
		scl = 1'b1;
		tick(10);
		sda_drv = 1'b1;
		tick(10);
	endtask
	// Low byte before high byte
	task automatic write_word(input logic [6:0] a, input logic [7:0] c, input logic [15:0] d,
		output logic ok);
		logic k0, k1, k2, k3;
		start();
		byte_io({a, 1'b0}, 1'b1, k0);
		byte_io(c, 1'b1, k1);
		byte_io(d[7:0], 1'b1, k2);
		byte_io(d[15:8], 1'b1, k3);
		stop();
		ok = !(k0 | k1 | k2 | k3);
	endtask
	task automatic read_word(input logic [6:0] a, output logic [15:0] d, output logic ok);
		logic k0, k1, k2, k3;
		start();
		byte_io({a, 1'b0}, 1'b1, k0);
		byte_io(CMD_OPTION, 1'b1, k1);
		start();
		byte_io({a, 1'b1}, 1'b1, k2);
		byte_io(8'hFF, 1'b0, k3);
		d[7:0] = rx;
		byte_io(8'hFF, 1'b1, k3);
		d[15:8] = rx;
		stop();
		ok = !(k0 | k1 | k2);
	endtask
endmodule

// ==== verification/tb_charger_option_control.sv ====
`timescale 1ns/1ns
module tb_charger_option_control;
	import coc_pkg::*;
	localparam logic [6:0] ADDR = 7'h2A;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic adp_in = 1'b0;
	logic below = 1'b0;
	logic above = 1'b0;
	logic [15:0] cv = 16'h1000;
	logic scl, sda_drv, sdo, oe, bps, aps, ok;
	logic [15:0] rd;
	wire logic [15:0] outs;
	int n_fail = 0;
	int compares = 0;
	int cycles = 0;
	wire logic sda = sda_drv & ~(oe & ~sdo);
	assign outs[15:13] = 3'h0;
	assign outs[3:2] = 2'h0;
	always #20 clk = ~clk;
	coc_smb_host host (.clk(clk), .scl(scl), .sda_drv(sda_drv), .sda(sda));
	coc_option_ctrl dut (
		.clk(clk), .sys_rst(sys_rst), .smb_clk(scl), .smb_data_in(sda),
		.smb_data_out(sdo), .smb_data_oe(oe), .adapter_detect_input(adp_in),
		.battery_below_falling(below), .battery_above_rising(above),
		.charge_voltage_setting(cv), .depletion_threshold_sel(outs[12:11]),
		.freq_adjust_up(outs[10]), .freq_adjust_en(outs[9]),
		.high_side_short_threshold(outs[8]), .low_side_short_threshold(outs[7]),
		.current_monitor_sel(outs[5]), .adapter_overcurrent_threshold(outs[1]),
		.charge_inhibit(outs[0]), .battery_path_switch(bps), .adapter_path_switch(aps),
		.adapter_present(outs[4]), .learn_active(outs[6])
	);
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 80000) begin
			n_fail++;
			conclude();
		end
	end
	task automatic conclude;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t ns: %s got %h expected %h", $time, m, got, exp);
		end
	endtask
	task automatic wr(input logic [15:0] v);
		host.write_word(ADDR, CMD_OPTION, v, ok);
		chk({15'h0, ok}, 16'h1, "write ack");
		tick(8);
	endtask
	task automatic rdv(input logic [15:0] e);
		host.read_word(ADDR, rd, ok);
		chk(rd, e, "read word");
	endtask
	task automatic t_reset;
		chk(outs, 16'h1902, "reset fields");
		chk({14'h0, bps, aps}, 16'h1, "reset path");
		rdv(16'h1902);
		$display("test reset done");
	endtask
	task automatic t_fields;
		wr(16'hE6BD);
		chk(outs, 16'h06A1, "fields");
		rdv(16'h06AD);
		for (int k = 0; k < 4; k++) begin
			wr({3'h0, 2'(k), 11'h102});
			chk(outs, {3'h0, 2'(k), 11'h102}, "threshold code");
		end
		$display("test fields done");
	endtask
	task automatic t_adapter;
		adp_in = 1'b1;
		tick(8);
		chk(outs, 16'h1912, "adapter present");
		wr(16'h1902);
		rdv(16'h1912);
		adp_in = 1'b0;
		tick(8);
		chk(outs, 16'h1902, "adapter gone");
		$display("test adapter done");
	endtask
	task automatic t_refuse;
		host.write_word(ADDR, 8'h14, 16'h0000, ok);
		chk({15'h0, ok}, 16'h0, "bad command");
		host.write_word(7'h2B, CMD_OPTION, 16'h0000, ok);
		chk({15'h0, ok}, 16'h0, "bad address");
		rdv(16'h1902);
		$display("test refuse done");
	endtask
	task automatic t_learn;
		wr(16'h1942);
		chk(outs, 16'h1942, "learn running");
		chk({14'h0, bps, aps}, 16'h2, "battery on");
		below = 1'b1;
		tick(10);
		chk({14'h0, bps, aps}, 16'h1, "depleted");
		chk(outs, 16'h1902, "learn ended");
		rdv(16'h1902);
		below = 1'b0;
		wr(16'h1942);
		chk(outs, 16'h1902, "hysteresis");
		above = 1'b1;
		tick(8);
		above = 1'b0;
		wr(16'h1942);
		chk(outs, 16'h1942, "restart");
		wr(16'h1902);
		chk({14'h0, bps, aps}, 16'h1, "abort");
		cv = 16'h0;
		below = 1'b1;
		wr(16'h1942);
		tick(10);
		chk(outs, 16'h1942, "zero voltage");
		wr(16'h1902);
		below = 1'b0;
		cv = 16'h1000;
		$display("test learn done");
	endtask
	initial begin
		tick(16);
		sys_rst = 1'b0;
		tick(4);
		t_reset();
		t_fields();
		t_adapter();
		t_refuse();
		t_learn();
		conclude();
	end
endmodule
